// ===== design/async_uart_receiver_status.sv
// The register addresses and the strobed register port were left to the implementer.
`default_nettype none
module async_uart_receiver_status
   import uart_rx_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic we,
   input wire logic re,
   input wire logic rx_pin,
   output logic [7:0] rdata,
   output logic rx_char_flag,
   output logic rx_irq
);
   logic [7:0] rcs_q;
   logic [7:0] txs_q;
   logic [7:0] bdc_q;
   logic [7:0] div_hi;
   logic [7:0] div_lo;
   logic [2:0] ien_q;
   logic [17:0] tick_cnt;
   logic s1, s2, s3;
   logic rx_level;
   logic [1:0] hist;
   rx_state_e state;
   logic [3:0] cnt;
   logic [3:0] bit_cnt;
   logic [8:0] sr;
   logic [9:0] fifo_mem [2];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic overrun_err;

   wire port_enable = rcs_q[RCS_PORT_EN];
   wire rx_nine_bit_sel = rcs_q[RCS_NINE_SEL];
   wire rx_continuous_en = rcs_q[RCS_CONT_EN];
   wire addr_detect_en = rcs_q[RCS_ADDR_DET];
   wire sync_mode = txs_q[TXS_SYNC];
   wire baud_high_speed = txs_q[TXS_HIGH_SPEED];
   wire baud_wide_sel = bdc_q[BDC_WIDE_SEL];
   wire rx_invert = bdc_q[BDC_RX_INVERT];
   wire rx_int_en = ien_q[IEN_RX];
   wire periph_int_en = ien_q[IEN_PERIPH];
   wire global_int_en = ien_q[IEN_GLOBAL];
   wire rx_on = port_enable & rx_continuous_en & ~sync_mode;

   // Oversample tick: one per sixteenth of a bit
   wire [15:0] div_n = baud_wide_sel ? {div_hi, div_lo} : {8'h00, div_lo};
   wire [17:0] div_p1 = {2'b00, div_n} + 18'h1;
   wire [17:0] quarter = {2'b00, div_p1[17:2]};
   wire [17:0] quarter_min = (quarter == 18'h0) ? 18'h1 : quarter;
   wire low_speed = ~baud_wide_sel & ~baud_high_speed;
   wire both_fast = baud_wide_sel & baud_high_speed;
   wire [17:0] tick_period = low_speed ? (div_p1 << LOW_SPEED_SHIFT) :
                             both_fast ? quarter_min : div_p1;
   wire [17:0] tick_last = tick_period - 18'h1;
   wire tick = rx_on & (tick_cnt >= tick_last);

   always_ff @(posedge clk) begin
      if (rst || !rx_on || tick)
         tick_cnt <= 18'h0;
      else
         tick_cnt <= tick_cnt + 18'h1;
   end

   // Pin filter: a change counts once the second and third stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         rx_level <= 1'b1;
      end else begin
         s1 <= rx_pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            rx_level <= s3;
      end
   end

   // Sync mode gives this bit another job, so no inversion there
   wire line = rx_level ^ (rx_invert & ~sync_mode);
   // Majority of the previous two samples and the current one
   wire maj = (hist[1] & hist[0]) | (hist[1] & line) | (hist[0] & line);
   wire [3:0] nbits_last = (rx_nine_bit_sel ? BITS_NINE : BITS_EIGHT) - 4'h1;

   always_ff @(posedge clk) begin
      if (rst || !rx_on)
         hist <= 2'b11;
      else if (tick)
         hist <= {hist[0], line};
   end

   always_ff @(posedge clk) begin
      if (rst || !rx_on) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         bit_cnt <= 4'h0;
         sr <= 9'h000;
      end else if (tick) begin
         case (state)
            ST_IDLE: begin
               cnt <= 4'h0;
               if (hist[0] && !line)
                  state <= ST_START;
            end
            ST_START: begin
               cnt <= cnt + 4'h1;
               if (cnt == HALF_BIT_LAST) begin
                  cnt <= 4'h0;
                  bit_cnt <= 4'h0;
                  state <= maj ? ST_IDLE : ST_DATA;
               end
            end
            ST_DATA: begin
               cnt <= cnt + 4'h1;
               if (cnt == FULL_BIT_LAST) begin
                  sr <= {maj, sr[8:1]};
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == nbits_last)
                     state <= ST_STOP;
               end
            end
            ST_STOP: begin
               cnt <= cnt + 4'h1;
               if (cnt == FULL_BIT_LAST)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Character completion and buffer entry
   wire char_done = tick & (state == ST_STOP) & (cnt == FULL_BIT_LAST);
   wire char_fe = ~maj;
   wire [8:0] char_word = rx_nine_bit_sel ? sr : {1'b0, sr[8:1]};
   // Address mode drops nine-bit characters whose ninth bit is clear
   wire keep = ~(addr_detect_en & rx_nine_bit_sel) | char_word[8];
   wire full = (count == 2'd2);
   // A read in the same cycle frees the slot that the new character takes
   wire room = ~full | pop;
   wire push = char_done & keep & ~overrun_err & room;
   wire overrun_set = char_done & keep & ~overrun_err & ~room;
   wire pop = re & (addr == OFF_RX_DATA) & (count != 2'd0);
   wire [1:0] next_count = !port_enable ? 2'd0 :
                           count + {1'b0, push} - {1'b0, pop};
   wire next_flag = port_enable & (next_count != 2'd0);

   always_ff @(posedge clk) begin
      if (push)
         fifo_mem[wr_ptr] <= {char_fe, char_word};
   end

   always_ff @(posedge clk) begin
      if (rst || !port_enable) begin
         count <= 2'd0;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
      end else begin
         count <= next_count;
         if (push)
            wr_ptr <= ~wr_ptr;
         if (pop)
            rd_ptr <= ~rd_ptr;
      end
   end

   // Set cannot meet a clear: a character only completes while enabled
   always_ff @(posedge clk) begin
      if (rst || !port_enable || !rx_continuous_en)
         overrun_err <= 1'b0;
      else if (overrun_set)
         overrun_err <= 1'b1;
   end

   wire [9:0] top = fifo_mem[rd_ptr];
   wire top_valid = (count != 2'd0);
   wire frame_err = top_valid & top[9];
   wire rx_ninth_bit = top_valid & top[8];
   wire [7:0] rx_byte = top_valid ? top[7:0] : 8'h00;
   wire rx_idle = (state == ST_IDLE);

   // Register read decode
   wire [7:0] rcs_read = {rcs_q[7:3], frame_err, overrun_err, rx_ninth_bit};
   // No transmitter here, so its shift register always reads empty
   wire [7:0] txs_read = {txs_q[7:2], 1'b1, txs_q[0]};
   wire [7:0] bdc_read = {1'b0, rx_idle, bdc_q[5:0]};
   wire [7:0] rd_mux =
      (addr == OFF_RX_STATUS_CTRL) ? rcs_read :
      (addr == OFF_RX_DATA) ? rx_byte :
      (addr == OFF_TX_STATUS_CTRL) ? txs_read :
      (addr == OFF_BAUD_CTRL) ? bdc_read :
      (addr == OFF_BAUD_DIV_HIGH) ? div_hi :
      (addr == OFF_BAUD_DIV_LOW) ? div_lo :
      (addr == OFF_INT_ENABLE) ? {5'h00, ien_q} :
      (addr == OFF_INT_FLAG) ? {7'h00, rx_char_flag} : 8'h00;

   always_ff @(posedge clk) begin
      if (rst)
         rdata <= 8'h00;
      else
         rdata <= re ? rd_mux : 8'h00;
   end

   // Register writes; status and flag fields are not writable
   always_ff @(posedge clk) begin
      if (rst) begin
         rcs_q <= RCS_RESET;
         txs_q <= TXS_RESET;
         bdc_q <= BDC_RESET;
         div_hi <= DIV_RESET;
         div_lo <= DIV_RESET;
         ien_q <= IEN_RESET;
      end else if (we) begin
         if (addr == OFF_RX_STATUS_CTRL)
            rcs_q <= wdata & RCS_WRITE_MASK;
         if (addr == OFF_TX_STATUS_CTRL)
            txs_q <= {wdata[7:2], 1'b0, wdata[0]};
         if (addr == OFF_BAUD_CTRL)
            bdc_q <= wdata & BDC_WRITE_MASK;
         if (addr == OFF_BAUD_DIV_HIGH)
            div_hi <= wdata;
         if (addr == OFF_BAUD_DIV_LOW)
            div_lo <= wdata;
         if (addr == OFF_INT_ENABLE)
            ien_q <= wdata[2:0];
      end
   end

   // Framing errors never reach the interrupt, only buffered data does
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_char_flag <= 1'b0;
         rx_irq <= 1'b0;
      end else begin
         rx_char_flag <= next_flag;
         rx_irq <= next_flag & rx_int_en & periph_int_en
                   & global_int_en;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_start_centre;
      (state == ST_START) && tick && (cnt == HALF_BIT_LAST);
   endsequence
   sequence s_line_high;
      maj;
   endsequence

   property p_false_start;
      (s_start_centre ##0 s_line_high) |=> (state == ST_IDLE);
   endproperty
   a_false_start: assert property (p_false_start)
      else $error("false start not aborted");

   property p_no_invert_sync;
      sync_mode |-> (line == rx_level);
   endproperty
   a_no_invert_sync: assert property (p_no_invert_sync)
      else $error("line inverted in synchronous mode");

   property p_flag_on_push;
      (push && port_enable) |=> rx_char_flag;
   endproperty
   a_flag_on_push: assert property (p_flag_on_push)
      else $error("flag not raised on buffer entry");

   property p_flag_not_writable;
      (we && addr == OFF_INT_FLAG && count == 2'd0 && !push)
         |=> !rx_char_flag;
   endproperty
   a_flag_not_writable: assert property (p_flag_not_writable)
      else $error("flag changed by software");

   property p_irq_gated;
      rx_irq |-> ($past(ien_q) == 3'h7) && rx_char_flag;
   endproperty
   a_irq_gated: assert property (p_irq_gated)
      else $error("interrupt without all enables");

   property p_overrun_set;
      overrun_set |=> overrun_err && (count == 2'd2);
   endproperty
   a_overrun_set: assert property (p_overrun_set)
      else $error("overrun not flagged");

   property p_overrun_blocks;
      overrun_err |-> !push;
   endproperty
   a_overrun_blocks: assert property (p_overrun_blocks)
      else $error("character accepted during overrun");

   property p_overrun_clear;
      $fell(overrun_err) |-> !$past(rx_continuous_en) || !$past(port_enable);
   endproperty
   a_overrun_clear: assert property (p_overrun_clear)
      else $error("overrun cleared without cause");

   property p_addr_filter;
      (push && addr_detect_en && rx_nine_bit_sel) |-> char_word[8];
   endproperty
   a_addr_filter: assert property (p_addr_filter)
      else $error("address mode buffered data character");

   property p_pop_advance;
      (pop && !push && port_enable) |=> (count == $past(count) - 2'd1);
   endproperty
   a_pop_advance: assert property (p_pop_advance)
      else $error("data read did not advance buffer");

   property p_port_off_clears;
      !port_enable |=> !frame_err && !rx_char_flag && !overrun_err;
   endproperty
   a_port_off_clears: assert property (p_port_off_clears)
      else $error("port disable left status set");

   sequence s_first_entry;
      push && (count == 2'd0);
   endsequence

   property p_fe_oldest;
      s_first_entry |=> (frame_err == $past(char_fe));
   endproperty
   a_fe_oldest: assert property (p_fe_oldest)
      else $error("framing status not shown for oldest");

   property p_ninth_oldest;
      s_first_entry |=> (rx_ninth_bit == $past(char_word[8]));
   endproperty
   a_ninth_oldest: assert property (p_ninth_oldest)
      else $error("ninth bit not shown for oldest");

   property p_lsb_first;
      (state == ST_DATA && tick && cnt == FULL_BIT_LAST)
         |=> (sr[8] == $past(maj));
   endproperty
   a_lsb_first: assert property (p_lsb_first)
      else $error("data bit not shifted in at top");

   property p_rx_continuous_en_keeps_fe;
      (port_enable && !rx_continuous_en && !pop && !we)
         |=> $stable(frame_err);
   endproperty
   a_rx_continuous_en_keeps_fe: assert property (p_rx_continuous_en_keeps_fe)
      else $error("framing status changed with receiver off");

   property p_irq_follows;
      (next_flag && ien_q == 3'h7) |=> rx_irq;
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("interrupt missing with all enables");
endmodule
`default_nettype wire

// ===== design/uart_rx_pkg.sv
`default_nettype none
package uart_rx_pkg;
   // Register offsets on the plain register port
   localparam logic [7:0] OFF_RX_STATUS_CTRL = 8'h00;
   localparam logic [7:0] OFF_RX_DATA = 8'h01;
   localparam logic [7:0] OFF_TX_STATUS_CTRL = 8'h02;
   localparam logic [7:0] OFF_BAUD_CTRL = 8'h03;
   localparam logic [7:0] OFF_BAUD_DIV_HIGH = 8'h04;
   localparam logic [7:0] OFF_BAUD_DIV_LOW = 8'h05;
   localparam logic [7:0] OFF_INT_ENABLE = 8'h06;
   localparam logic [7:0] OFF_INT_FLAG = 8'h07;

   // receive_status_control fields
   localparam int RCS_PORT_EN = 7;
   localparam int RCS_NINE_SEL = 6;
   localparam int RCS_CONT_EN = 4;
   localparam int RCS_ADDR_DET = 3;
   // transmit_status_control fields
   localparam int TXS_SYNC = 4;
   localparam int TXS_HIGH_SPEED = 2;
   localparam int TXS_SHIFT_EMPTY = 1;
   // baud_control fields
   localparam int BDC_RX_IDLE = 6;
   localparam int BDC_RX_INVERT = 5;
   localparam int BDC_WIDE_SEL = 3;
   // interrupt enable fields
   localparam int IEN_RX = 0;
   localparam int IEN_PERIPH = 1;
   localparam int IEN_GLOBAL = 2;

   // Values after reset, and register write masks
   localparam logic [7:0] RCS_RESET = 8'h00;
   localparam logic [7:0] TXS_RESET = 8'h00;
   localparam logic [7:0] BDC_RESET = 8'h00;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [2:0] IEN_RESET = 3'h0;
   localparam logic [7:0] RCS_WRITE_MASK = 8'hf8;
   localparam logic [7:0] BDC_WRITE_MASK = 8'h3b;

   // Oversampling counts, in oversample ticks, and data bits per character
   localparam logic [3:0] HALF_BIT_LAST = 4'h7;
   localparam logic [3:0] FULL_BIT_LAST = 4'hf;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
   // Shift of the divider count for the low-speed 8-bit divider: four times (divider + 1) clock cycles per tick
   localparam logic [1:0] LOW_SPEED_SHIFT = 2'h2;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_START = 4'b0010,
      ST_DATA = 4'b0100,
      ST_STOP = 4'b1000
   } rx_state_e;
endpackage
`default_nettype wire

// ===== testbench/serial_tx_model.sv
`default_nettype none
module serial_tx_model (
   input wire logic clk,
   input wire logic go,
   input wire logic [8:0] data,
   input wire logic nine,
   input wire logic bad_stop,
   input wire logic invert,
   input wire logic glitch,
   output logic line,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT_CLKS = 16;
   logic [10:0] sh = 11'h7ff;
   int bits = 0;
   int cnt = 0;
   assign busy = (bits != 0);
   // Idle high in true polarity; glitch is a short false start
   assign line = (glitch ? 1'b0 : (busy ? sh[0] : 1'b1)) ^ invert;
   always @(posedge clk) begin
      if (go && !busy) begin
         // Start low, data LSB first, one stop bit
         sh <= nine ? {~bad_stop, data, 1'b0}
                    : {1'b1, ~bad_stop, data[7:0], 1'b0};
         bits <= nine ? 11 : 10;
         cnt <= 0;
      end else if (busy) begin
         if (cnt == BIT_CLKS - 1) begin
            cnt <= 0;
            sh <= {1'b1, sh[10:1]};
            bits <= bits - 1;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== testbench/test_async_uart_receiver_status.sv
`default_nettype none
module test_async_uart_receiver_status;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
   logic rx_pin, rx_char_flag, rx_irq, go = 1'b0, nine = 1'b0;
   logic bad = 1'b0, inv = 1'b0, glitch = 1'b0, busy;
   logic [8:0] tdata = 9'h000;
   int n_mismatch = 0, comparisons = 0, k;
   logic [7:0] k8[7] = '{8'h00, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h3c};
   async_uart_receiver_status u_dut (.clk(clk), .rst(rst), .addr(addr),
      .wdata(wdata), .we(we), .re(re), .rx_pin(rx_pin), .rdata(rdata),
      .rx_char_flag(rx_char_flag), .rx_irq(rx_irq));
   serial_tx_model u_tx (.clk(clk), .go(go), .data(tdata), .nine(nine),
      .bad_stop(bad), .invert(inv), .glitch(glitch), .line(rx_pin),
      .busy(busy));
   initial forever #2.5 clk = ~clk;
   function automatic logic [7:0] st(input logic [7:0] c, input logic [2:0] s);
      return (c & 8'hf8) | {5'h00, s};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic send(input logic [8:0] v, input logic b);
      int i;
      @(posedge clk);
      tdata <= v;
      bad <= b;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (i = 0; i < 400; i++) begin
         @(negedge clk);
         if (!busy) break;
      end
      repeat (8) @(posedge clk);
   endtask
   task automatic pins(input logic f, input logic q);
      repeat (2) @(posedge clk);
      #1 chk({6'h00, rx_irq, rx_char_flag}, {6'h00, q, f});
   endtask
   task automatic report_and_stop;
      $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #250000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      void'($urandom(40422));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      foreach (k8[i]) rd(k8[i], (k8[i] == 8'h02) ? 8'h02 : 8'h00);
      rd(8'h03, 8'h40);
      wr(8'h07, 8'h01);
      rd(8'h07, 8'h00);
      $display("test reset done");
      wr(8'h02, 8'h04);
      wr(8'h05, 8'h00);
      wr(8'h06, 8'h07);
      wr(8'h00, 8'h90);
      for (k = 0; k < 4; k++) begin
         d = 8'($urandom);
         send({1'b0, d}, 1'b0);
         pins(1'b1, 1'b1);
         rd(8'h00, st(8'h90, 3'h0));
         rd(8'h01, d);
         pins(1'b0, 1'b0);
      end
      $display("test random done");
      send(9'h0a5, 1'b1);
      send(9'h03c, 1'b0);
      rd(8'h00, st(8'h90, 3'h4));
      rd(8'h01, 8'ha5);
      rd(8'h00, st(8'h90, 3'h0));
      rd(8'h01, 8'h3c);
      $display("test framing done");
      wr(8'h06, 8'h03);
      send(9'h055, 1'b0);
      pins(1'b1, 1'b0);
      wr(8'h06, 8'h07);
      pins(1'b1, 1'b1);
      rd(8'h01, 8'h55);
      $display("test mask done");
      send(9'h011, 1'b0);
      send(9'h022, 1'b0);
      send(9'h033, 1'b0);
      rd(8'h00, st(8'h90, 3'h2));
      send(9'h044, 1'b0);
      rd(8'h01, 8'h11);
      rd(8'h01, 8'h22);
      pins(1'b0, 1'b0);
      wr(8'h00, 8'h80);
      rd(8'h00, 8'h80);
      $display("test overrun done");
      wr(8'h00, 8'h90);
      send(9'h066, 1'b1);
      wr(8'h00, 8'h80);
      rd(8'h00, st(8'h80, 3'h4));
      wr(8'h00, 8'h00);
      rd(8'h00, 8'h00);
      $display("test port enable done");
      nine <= 1'b1;
      wr(8'h00, 8'hd0);
      send(9'h1a7, 1'b0);
      rd(8'h00, st(8'hd0, 3'h1));
      rd(8'h01, 8'ha7);
      wr(8'h00, 8'hd8);
      send(9'h0b2, 1'b0);
      pins(1'b0, 1'b0);
      send(9'h1c3, 1'b0);
      rd(8'h00, st(8'hd8, 3'h1));
      rd(8'h01, 8'hc3);
      wr(8'h00, 8'hd0);
      send(9'h044, 1'b0);
      rd(8'h00, st(8'hd0, 3'h0));
      rd(8'h01, 8'h44);
      nine <= 1'b0;
      $display("test nine bit done");
      wr(8'h00, 8'h90);
      @(posedge clk);
      glitch <= 1'b1;
      repeat (4) @(posedge clk);
      glitch <= 1'b0;
      repeat (200) @(posedge clk);
      pins(1'b0, 1'b0);
      $display("test glitch done");
      // Port off while polarity flips, else the edge looks like a start
      wr(8'h00, 8'h00);
      wr(8'h03, 8'h20);
      inv <= 1'b1;
      wr(8'h00, 8'h90);
      repeat (40) @(posedge clk);
      d = 8'($urandom);
      send({1'b0, d}, 1'b0);
      rd(8'h00, st(8'h90, 3'h0));
      rd(8'h01, d);
      $display("test invert done");
      wr(8'h02, 8'h14);
      rd(8'h02, 8'h16);
      rd(8'h03, 8'h60);
      send({1'b0, d}, 1'b0);
      pins(1'b0, 1'b0);
      $display("test sync done");
      report_and_stop();
   end
endmodule
`default_nettype wire
